// >>> design/hvi_defines.svh
// Constants of the HDLC vector interface: addresses, field positions, reset values.
// Assumes a 16-bit word-addressed register port shared by DSP and device.
`ifndef HVI_DEFINES_SVH
`define HVI_DEFINES_SVH

`define HVI_CTRL_ADDR 16'hd180
`define HVI_CMD_BASE 16'h4040
`define HVI_STAT_BASE 16'h40a0
`define HVI_NCHAN 32
`define HVI_MAX_PRESET 6'h20
`define HVI_STATUS_RESET 16'h0001

`define HVI_GS_OWN 0
`define HVI_GS_PRESET_LO 1
`define HVI_GS_COUNT_LO 7
`define HVI_GS_ORDER 14
`define HVI_GS_DONE 15

`define HVI_CV_IDLE 0
`define HVI_CV_CRC 1
`define HVI_CV_TX_LO 2
`define HVI_CV_RXRES 5
`define HVI_CV_DSEL 6

`define HVI_SV_NO 0
`define HVI_SV_CRC 1
`define HVI_SV_STOP 2
`define HVI_SV_ABORT 3
`define HVI_SV_FULL 4
`define HVI_SV_EMPTY 5
`define HVI_SV_FLAG 6

`define HVI_MASK_B 8'hff
`define HVI_MASK_D 8'hc0

`endif

// >>> design/hvi_dev_end.sv
// Device end: global status, control, command and status vectors, channel walk.
// Assumes the engine pulses eng_step once per channel on the same clock.
//
// Local design decision: strobed register access.
`include "hvi_defines.svh"

module hvi_dev_end
  import hvi_pkg::*;
(
  input wire logic clk, // System clock, 20 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  hvi_if.dev bus, // DSP register port.
  input wire logic eng_step, // Engine finished the current channel.
  input wire logic ev_rx_octet, // A received octet is waiting.
  input wire logic ev_not_octet, // Message ended off an octet boundary.
  input wire logic ev_crc_err, // CRC failed for the ended message.
  input wire logic ev_eom, // End-of-message flag seen.
  input wire logic ev_abort, // Seven ones received.
  input wire logic ev_tx_used, // Transmit slot consumed.
  output hvi_chan_t cur_chan, // Channel being processed.
  output logic engine_run, // Engine owns the buffers and the frame is not done.
  output logic frame_done, // Frame processing finished.
  output logic bit_order_select, // 1 sends LSB first.
  output logic [7:0] rx_bit_mask, // Receive bits the protocol covers.
  output logic rx_crc_en, // Receive CRC check on.
  output logic receiver_reset, // Hold this channel's receiver in reset.
  output logic [7:0] tx_bit_mask, // Transmit bits the protocol covers.
  output logic tx_crc_en, // Transmit CRC generation on.
  output logic tx_active, // Transmission runs.
  output logic tx_second_bit, // Start at second D-channel bit.
  output logic tx_flag_start, // Start with a flag after inserted 0111.
  output logic tx_abort, // Send an abort.
  output logic tx_idle_flags // Idle channel sends flags, else ones.
);

  typedef struct packed
  {
    logic own;
    logic [5:0] preset;
    logic order;
    logic [5:0] count;
    logic done;
    logic [15:0] rdata;
  } hvi_dev_s;

  hvi_dev_s s_q;
  hvi_dev_s s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic hit_ctrl;
  logic hit_cmd;
  logic hit_stat;
  logic step_ok;
  hvi_word_t status_word;
  hvi_vec_t cmd_dsp;
  hvi_vec_t cmd_cur;
  hvi_vec_t stat_dsp;
  hvi_vec_t stat_cur;
  hvi_vec_t stat_set;
  hvi_vec_t stat_clr;
  logic stat_set_en;
  logic stat_clr_en;
  hvi_chan_t stat_clr_addr;
  hvi_transmit_command_e txc;

  assign hit_ctrl = (bus.addr == `HVI_CTRL_ADDR);
  assign hit_cmd = (bus.addr[15:5] == `HVI_CMD_BASE >> 5);
  assign hit_stat = (bus.addr[15:5] == `HVI_STAT_BASE >> 5);
  assign step_ok = eng_step && !s_q.own && !s_q.done;

  always_comb
  begin
    status_word = 16'h0000;
    status_word[`HVI_GS_OWN] = s_q.own;
    status_word[`HVI_GS_PRESET_LO +: 6] = s_q.preset;
    status_word[`HVI_GS_COUNT_LO +: 6] = s_q.count;
    status_word[`HVI_GS_ORDER] = s_q.order;
    status_word[`HVI_GS_DONE] = s_q.done;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Vector stores.

  // The command store is rewritten whole: clear all bits, set the new value.
  hvi_vram u_cmd
  (
    .clk(clk),
    .rstn(rstn),
    .set_en(bus.wr && hit_cmd && s_q.own),
    .set_addr(bus.addr[4:0]),
    .set_bits(bus.wdata[6:0]),
    .clr_en(bus.wr && hit_cmd && s_q.own),
    .clr_addr(bus.addr[4:0]),
    .clr_bits(7'h7f),
    .rd_addr_a(bus.addr[4:0]),
    .rd_data_a(cmd_dsp),
    .rd_addr_b(s_q.count[4:0]),
    .rd_data_b(cmd_cur)
  );

  always_comb
  begin
    stat_set = 7'h00;
    stat_set[`HVI_SV_NO] = ev_not_octet;
    stat_set[`HVI_SV_CRC] = ev_eom && ev_crc_err;
    stat_set[`HVI_SV_STOP] = ev_eom || ev_abort;
    stat_set[`HVI_SV_ABORT] = ev_abort;
    stat_set[`HVI_SV_FULL] = ev_rx_octet;
    stat_set[`HVI_SV_EMPTY] = ev_tx_used;
    stat_set[`HVI_SV_FLAG] = ev_rx_octet || ev_tx_used;
    stat_set_en = step_ok;
    // The engine clears a stale CRC error at each error-free message end; the DSP clears
    // every flag it has read. The two never meet, as ownership separates them.
    stat_clr = 7'h00;
    stat_clr_en = 1'b0;
    stat_clr_addr = s_q.count[4:0];
    if (step_ok && ev_eom && !ev_crc_err)
    begin
      stat_clr[`HVI_SV_CRC] = 1'b1;
      stat_clr_en = 1'b1;
    end
    else if (bus.rd && hit_stat && s_q.own)
    begin
      stat_clr = 7'h7f;
      stat_clr_en = 1'b1;
      stat_clr_addr = bus.addr[4:0];
    end
  end

  hvi_vram u_stat
  (
    .clk(clk),
    .rstn(rstn),
    .set_en(stat_set_en),
    .set_addr(s_q.count[4:0]),
    .set_bits(stat_set),
    .clr_en(stat_clr_en),
    .clr_addr(stat_clr_addr),
    .clr_bits(stat_clr),
    .rd_addr_a(bus.addr[4:0]),
    .rd_data_a(stat_dsp),
    .rd_addr_b(s_q.count[4:0]),
    .rd_data_b(stat_cur)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Control, read path and channel walk.

  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 16'h0000;
    if (bus.rd)
    begin
      if (hit_ctrl)
      begin
        s_d.rdata = status_word;
      end
      else if (hit_cmd && s_q.own)
      begin
        s_d.rdata = {9'h000, cmd_dsp};
      end
      else if (hit_stat && s_q.own)
      begin
        s_d.rdata = {9'h000, stat_dsp};
      end
    end
    if (bus.wr && hit_ctrl)
    begin
      s_d.own = bus.wdata[`HVI_GS_OWN];
      s_d.order = bus.wdata[`HVI_GS_ORDER];
      if (bus.wdata[`HVI_GS_OWN])
      begin
        // Presets above 32 channels are clipped to the store size.
        if (bus.wdata[`HVI_GS_PRESET_LO +: 6] > `HVI_MAX_PRESET)
        begin
          s_d.preset = `HVI_MAX_PRESET;
        end
        else
        begin
          s_d.preset = bus.wdata[`HVI_GS_PRESET_LO +: 6];
        end
      end
      else
      begin
        s_d.count = 6'h00;
        s_d.done = (s_q.preset == 6'h00);
      end
    end
    else if (step_ok)
    begin
      s_d.count = s_q.count + 6'h01;
      s_d.done = (s_q.count + 6'h01 >= s_q.preset);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.own <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Engine-side view of the current channel's command.

  assign txc = hvi_transmit_command_e'(cmd_cur[`HVI_CV_TX_LO +: 3]);
  assign bus.rdata = s_q.rdata;
  assign cur_chan = s_q.count[4:0];
  assign engine_run = !s_q.own && !s_q.done;
  assign frame_done = s_q.done;
  assign bit_order_select = s_q.order;
  assign rx_bit_mask = cmd_cur[`HVI_CV_DSEL] ? `HVI_MASK_D : `HVI_MASK_B;
  assign rx_crc_en = cmd_cur[`HVI_CV_CRC];
  assign receiver_reset = cmd_cur[`HVI_CV_RXRES];
  assign tx_bit_mask = cmd_cur[`HVI_CV_DSEL] ? `HVI_MASK_D : `HVI_MASK_B;
  assign tx_crc_en = cmd_cur[`HVI_CV_CRC];
  assign tx_active = (txc == HVI_TX_D1) || (txc == HVI_TX_D2) || (txc == HVI_TX_FLAG);
  assign tx_second_bit = (txc == HVI_TX_D2);
  assign tx_flag_start = (txc == HVI_TX_FLAG);
  assign tx_abort = (txc == HVI_TX_ABORT);
  assign tx_idle_flags = cmd_cur[`HVI_CV_IDLE];

endmodule

// >>> design/hvi_dsp_end.sv
// DSP end: turns user requests into register-port cycles, guards vector access.
// Assumes the device answers a read in the cycle after the strobe.
`include "hvi_defines.svh"

module hvi_dsp_end
  import hvi_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  hvi_if.dsp bus, // Register port to the device.
  input wire logic req_wr, // Write request, one cycle.
  input wire logic req_rd, // Read request, one cycle.
  input wire hvi_word_t req_addr, // Request address.
  input wire hvi_word_t req_wdata, // Request write data.
  output logic rsp_valid, // Read data valid, one cycle.
  output hvi_word_t rsp_data, // Read data.
  output logic req_refused, // Vector access refused, one cycle.
  output logic owns_buffers // DSP believes it owns the buffers.
);

  typedef struct packed
  {
    hvi_word_t addr;
    hvi_word_t wdata;
    logic wr;
    logic rd;
    logic rd_ctrl;
    logic rd_dly;
    logic ctrl_dly;
    logic rsp_valid;
    hvi_word_t rsp_data;
    logic refused;
    logic own;
  } hvi_dsp_s;

  hvi_dsp_s s_q;
  hvi_dsp_s s_d;
  logic is_vec;

  assign is_vec = (req_addr[15:5] == `HVI_CMD_BASE >> 5)
    || (req_addr[15:5] == `HVI_STAT_BASE >> 5);

  always_comb
  begin
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    s_d.refused = 1'b0;
    // Read data stands only in the cycle after the strobe, so the answer is
    // taken one cycle later than the strobe itself.
    s_d.rsp_valid = s_q.rd_dly;
    s_d.rd_dly = s_q.rd;
    s_d.ctrl_dly = s_q.rd_ctrl;
    s_d.rd_ctrl = 1'b0;
    if (s_q.rd_dly)
    begin
      s_d.rsp_data = bus.rdata;
      if (s_q.ctrl_dly)
      begin
        s_d.own = bus.rdata[`HVI_GS_OWN];
      end
    end
    if ((req_wr || req_rd) && is_vec && !s_q.own)
    begin
      s_d.refused = 1'b1;
    end
    else if (req_wr || req_rd)
    begin
      s_d.addr = req_addr;
      s_d.wdata = req_wdata;
      s_d.wr = req_wr;
      s_d.rd = req_rd && !req_wr;
      s_d.rd_ctrl = req_rd && !req_wr && (req_addr == `HVI_CTRL_ADDR);
      if (req_wr && req_addr == `HVI_CTRL_ADDR)
      begin
        s_d.own = req_wdata[`HVI_GS_OWN];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.own <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign bus.addr = s_q.addr;
  assign bus.wdata = s_q.wdata;
  assign bus.wr = s_q.wr;
  assign bus.rd = s_q.rd;
  assign rsp_valid = s_q.rsp_valid;
  assign rsp_data = s_q.rsp_data;
  assign req_refused = s_q.refused;
  assign owns_buffers = s_q.own;

endmodule

// >>> design/hvi_if.sv
// Register port between the DSP end and the device end.
// Assumes one clock; read data stands in the cycle after the read strobe.
interface hvi_if;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;

  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport dsp (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// >>> design/hvi_pkg.sv
// Types shared by both ends of the HDLC vector interface.
// Widths and transmit command codes are literals here; other numeric constants are in hvi_defines.svh.
package hvi_pkg;

  typedef logic [15:0] hvi_word_t;
  typedef logic [6:0] hvi_vec_t;
  typedef logic [4:0] hvi_chan_t;

  typedef enum logic [2:0]
  {
    HVI_TX_END = 3'h0,
    HVI_TX_D1 = 3'h1,
    HVI_TX_D2 = 3'h2,
    HVI_TX_FLAG = 3'h3,
    HVI_TX_ABORT = 3'h4
  } hvi_transmit_command_e;

endpackage

// >>> design/hvi_vram.sv
// Per-channel 7-bit vector store with set and clear ports and two read ports.
// Assumes set and clear may hit one entry at once; the set then wins.
`include "hvi_defines.svh"

module hvi_vram
  import hvi_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic set_en, // Set bits of one entry.
  input wire hvi_chan_t set_addr, // Entry to set.
  input wire hvi_vec_t set_bits, // Bits to set.
  input wire logic clr_en, // Clear bits of one entry.
  input wire hvi_chan_t clr_addr, // Entry to clear.
  input wire hvi_vec_t clr_bits, // Bits to clear.
  input wire hvi_chan_t rd_addr_a, // First read address.
  output hvi_vec_t rd_data_a, // First read data.
  input wire hvi_chan_t rd_addr_b, // Second read address.
  output hvi_vec_t rd_data_b // Second read data.
);

  typedef struct packed
  {
    logic [`HVI_NCHAN-1:0][6:0] mem;
  } hvi_vram_s;

  hvi_vram_s s_q;
  hvi_vram_s s_d;

  always_comb
  begin
    s_d = s_q;
    for (int i = 0; i < `HVI_NCHAN; i++)
    begin
      if (clr_en && clr_addr == i[4:0])
      begin
        s_d.mem[i] = s_d.mem[i] & ~clr_bits;
      end
      if (set_en && set_addr == i[4:0])
      begin
        s_d.mem[i] = s_d.mem[i] | set_bits;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rd_data_a = s_q.mem[rd_addr_a];
  assign rd_data_b = s_q.mem[rd_addr_b];

endmodule

// >>> verification/hvi_chk.sv
// Assertions on the register port joining the two ends.
// Assumes it sees the interface signals, one clock and one reset.
module hvi_chk (
  input wire logic clk, // System clock.
  input wire logic rstn, // Reset, active low.
  input wire logic [15:0] addr, // Word address.
  input wire logic [15:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  input wire logic [15:0] rdata // Read data.
);
  logic own_q;
  logic ord_q;
  logic [5:0] pre_q;
  logic [15:0] la_q;
  logic [6:0] ld_q;
  logic ctl;
  logic cmd;
  logic vec;
  assign ctl = addr == 16'hd180;
  assign cmd = addr[15:5] == 11'h202;
  assign vec = cmd || addr[15:5] == 11'h205;
  ////////////////////////////////////////////////////////////////////////////////
  // Mirror of the control fields and the last command write, kept from the bus alone.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      own_q <= 1'b1;
      ord_q <= 1'b0;
      pre_q <= 6'h00;
      la_q <= 16'h0000;
      ld_q <= 7'h00;
    end
    else if (wr && ctl)
    begin
      own_q <= wdata[0];
      ord_q <= wdata[14];
      if (wdata[0])
        pre_q <= (wdata[6:1] > 6'h20) ? 6'h20 : wdata[6:1];
    end
    else if (wr && cmd && own_q)
    begin
      la_q <= addr;
      ld_q <= wdata[6:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_one_strobe:
    assert property (!(wr && rd)) else $error("both strobes high");
  a_rdata_idle:
    assert property (!$past(rd) |-> rdata == 16'h0000) else $error("read data not idle");
  a_own_bit:
    assert property (rd && ctl |=> rdata[0] == own_q) else $error("ownership bit wrong");
  a_preset_bits:
    assert property (rd && ctl |=> rdata[6:1] == pre_q) else $error("preset field wrong");
  a_order_bit:
    assert property (rd && ctl |=> rdata[14] == ord_q) else $error("bit order wrong");
  a_vec_upper:
    assert property (rd && vec |=> rdata[15:7] == 9'h000) else $error("vector upper bits set");
  a_unmapped_zero:
    assert property (rd && !ctl && !vec |=> rdata == 16'h0000) else $error("unmapped read data");
  a_cmd_back:
    assert property (rd && cmd && addr == la_q |=> rdata[6:0] == ld_q)
    else $error("command readback wrong");
endmodule

// >>> verification/multichannel_hdlc_vector_interface_tb_top.sv
// Bench joining the DSP end and the device end through one interface.
// Assumes the user port and engine inputs are driven here, one clock of 50 ns.
module multichannel_hdlc_vector_interface_tb_top
  import hvi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, req_wr, req_rd, eng_step, rsp_valid, req_refused, owns_buffers;
  logic engine_run, frame_done, bit_order_select, rx_crc_en, receiver_reset, tx_crc_en;
  logic tx_active, tx_second_bit, tx_flag_start, tx_abort, tx_idle_flags;
  logic [5:0] ev;
  logic [7:0] rx_bit_mask, tx_bit_mask;
  hvi_word_t req_addr, req_wdata, rsp_data;
  hvi_chan_t cur_chan;
  int bad_count = 0;
  int checks_done = 0;
  hvi_if bus_if ();
  hvi_dsp_end i_hvi_dsp_end (.clk(clk), .rstn(rstn), .bus(bus_if), .req_wr(req_wr),
    .req_rd(req_rd), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .req_refused(req_refused), .owns_buffers(owns_buffers));
  hvi_dev_end i_hvi_dev_end (.clk(clk), .rstn(rstn), .bus(bus_if), .eng_step(eng_step),
    .ev_rx_octet(ev[0]), .ev_not_octet(ev[1]), .ev_crc_err(ev[2]), .ev_eom(ev[3]),
    .ev_abort(ev[4]), .ev_tx_used(ev[5]), .cur_chan(cur_chan), .engine_run(engine_run),
    .frame_done(frame_done), .bit_order_select(bit_order_select), .rx_bit_mask(rx_bit_mask),
    .rx_crc_en(rx_crc_en), .receiver_reset(receiver_reset), .tx_bit_mask(tx_bit_mask),
    .tx_crc_en(tx_crc_en), .tx_active(tx_active), .tx_second_bit(tx_second_bit),
    .tx_flag_start(tx_flag_start), .tx_abort(tx_abort), .tx_idle_flags(tx_idle_flags));
  hvi_chk i_hvi_chk (.clk(clk), .rstn(rstn), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    $display("ERROR %0t wait timed out", $time);
    test_done;
  endtask
  task automatic wr_reg(input hvi_word_t a, input hvi_word_t d);
    @(posedge clk);
    req_wr <= 1'b1;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // The answer is either read data or a refusal; a stale rsp_data is returned on refusal.
  task automatic rd_reg(input hvi_word_t a, output hvi_word_t d, output logic r);
    int n;
    @(posedge clk);
    req_rd <= 1'b1;
    req_addr <= a;
    @(posedge clk);
    req_rd <= 1'b0;
    for (n = 0; n < 8; n++)
    begin
      #1;
      if (rsp_valid === 1'b1 || req_refused === 1'b1)
        break;
      @(posedge clk);
    end
    if (n == 8)
      hang;
    d = rsp_data;
    r = req_refused;
  endtask
  task automatic rd_chk(input hvi_word_t a, input hvi_word_t e);
    hvi_word_t d;
    logic r;
    rd_reg(a, d, r);
    chk(d, e);
  endtask
  task automatic step(input logic [5:0] e);
    @(posedge clk);
    eng_step <= 1'b1;
    ev <= e;
    @(posedge clk);
    eng_step <= 1'b0;
    ev <= 6'h00;
    #1;
  endtask
  task automatic run_frame(input logic [5:0] pre);
    int n;
    wr_reg(16'hd180, {9'h000, pre, 1'b1});
    wr_reg(16'hd180, 16'h0000);
    for (n = 0; n < 8 && engine_run !== 1'b1; n++)
      @(posedge clk);
    if (n == 8)
      hang;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(16'hd180, 16'h0001);
    chk({14'h0000, frame_done, bit_order_select}, 16'h0000);
    wr_reg(16'h1234, 16'hffff);
    rd_chk(16'h1234, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_ctrl;
    wr_reg(16'hd180, 16'h4005);
    rd_chk(16'hd180, 16'h4005);
    chk({15'h0000, bit_order_select}, 16'h0001);
    wr_reg(16'hd180, 16'h007f);
    rd_chk(16'hd180, 16'h0041);
    wr_reg(16'hd180, 16'h0002);
    rd_chk(16'hd180, 16'h0040);
    wr_reg(16'hd180, 16'h0001);
    $display("test control done");
  endtask
  task automatic t_cmd;
    logic [6:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = {i[0], i[1], i[2:0], i[2], i[0]};
      wr_reg(16'h4040, {9'h000, v});
      rd_chk(16'h4040, {9'h000, v});
      chk({tx_bit_mask, rx_bit_mask}, i[0] ? 16'hc0c0 : 16'hffff);
      chk({12'h000, receiver_reset, rx_crc_en, tx_crc_en, tx_idle_flags},
          {12'h000, i[1], i[2], i[2], i[0]});
      chk({12'h000, tx_active, tx_second_bit, tx_flag_start, tx_abort},
          {12'h000, i > 0 && i < 4, i == 2, i == 3, i == 4});
    end
    wr_reg(16'h405f, 16'hffff);
    rd_chk(16'h405f, 16'h007f);
    $display("test command done");
  endtask
  task automatic t_frame;
    hvi_word_t d;
    logic r;
    step(6'h01);
    chk({11'h000, cur_chan}, 16'h0000);
    run_frame(6'h02);
    rd_reg(16'h40a0, d, r);
    chk({15'h0000, r}, 16'h0001);
    step(6'h01);
    step(6'h30);
    step(6'h01);
    chk({11'h000, cur_chan}, 16'h0002);
    chk({14'h0000, engine_run, frame_done}, 16'h0001);
    chk({15'h0000, owns_buffers}, 16'h0000);
    rd_chk(16'hd180, 16'h8104);
    wr_reg(16'hd180, 16'h0005);
    rd_chk(16'h40a0, 16'h0050);
    rd_chk(16'h40a0, 16'h0000);
    rd_chk(16'h40a1, 16'h006c);
    run_frame(6'h03);
    step(6'h0e);
    step(6'h00);
    step(6'h00);
    wr_reg(16'hd180, 16'h0007);
    rd_chk(16'h40a0, 16'h0007);
    rd_chk(16'h40a2, 16'h0000);
    run_frame(6'h01);
    step(6'h0c);
    run_frame(6'h01);
    step(6'h08);
    wr_reg(16'hd180, 16'h0003);
    chk({15'h0000, owns_buffers}, 16'h0001);
    rd_chk(16'h40a0, 16'h0004);
    $display("test frame done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    req_wr = 1'b0;
    req_rd = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
    eng_step = 1'b0;
    ev = 6'h00;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_ctrl;
    t_cmd;
    t_frame;
    test_done;
  end
endmodule
